// *** design/receive_bist_pattern_checker.sv ***
// Receive-side self-test pattern generator and checker on the decoder output.
`timescale 1ns/1ps
`default_nettype none

module receive_bist_pattern_checker
    import rx_selftest_pkg::*;
#(
    parameter int ERR_LIMIT = rx_selftest_pkg::ERR_LIMIT_DEF,
    parameter int ERR_WINDOW = rx_selftest_pkg::ERR_WINDOW_DEF
)
(
    // Recovered character clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Mode
    input wire logic receive_selftest_enable_n,
    // Decoded character from the decoder tables
    input wire logic [rx_selftest_pkg::CODE_W-1:0] decoded_code,
    input wire logic decoded_special,
    input wire logic decoded_error,
    // Output register toward the receive formatter
    output logic [rx_selftest_pkg::CODE_W-1:0] char_out,
    output logic special_or_data_flag,
    output logic code_violation_out,
    // Self-test status
    output logic receive_violation_signal,
    output logic receive_full_flag,
    output logic selftest_synced
);
    import rx_selftest_pkg::*;

    if (ERR_LIMIT < 1 || ERR_LIMIT > 255 || ERR_WINDOW < ERR_LIMIT
        || ERR_WINDOW > 65535)
    begin : g_bad_params
        $error("receive_bist_pattern_checker: bad abort parameters");
    end

    // Package constants must describe one maximal 9-stage loop
    if (STATE_W != CODE_W + 1 || LOOP_LEN != (1 << STATE_W) - 1
        || TAP_A != STATE_W - 1 || TAP_B >= TAP_A)
    begin : g_bad_loop
        $error("receive_bist_pattern_checker: bad generator constants");
    end

    // Abort threshold as sized constants
    localparam logic [7:0] ERR_LIMIT_V = 8'(ERR_LIMIT);
    localparam logic [15:0] WIN_LAST_V = 16'(ERR_WINDOW - 1);

    check_state_type state;
    check_state_type next_state;
    logic [STATE_W-1:0] pattern_shift_generator;
    logic [STATE_W-1:0] next_pattern;
    logic [7:0] err_count;
    logic [15:0] win_count;

    // Generated character for this slot
    wire logic gen_special = pattern_shift_generator[STATE_W-1];
    wire logic [CODE_W-1:0] gen_code = pattern_shift_generator[CODE_W-1:0];
    wire logic feedback = ~(pattern_shift_generator[TAP_A]
                          ^ pattern_shift_generator[TAP_B]);
    // XNOR feedback keeps all-zero legal, giving a 511-state loop from 00
    wire logic [STATE_W-1:0] pattern_step =
        {pattern_shift_generator[STATE_W-2:0], feedback};         // [R3] [R11]

    wire logic selftest_on = ~receive_selftest_enable_n;          // [R2]
    wire logic start_seen = ~decoded_special
                          && (decoded_code == CODE_RST);          // [R5]
    // Mismatch ignores decoder error flag in self-test
    wire logic mismatch = (decoded_special != gen_special)
                        || (decoded_code != gen_code);            // [R6] [R8]
    wire logic at_loop_start = (pattern_shift_generator == START_STATE);
    wire logic checking = (state == ST_CHECK);
    // Only characters compared after sync can count as errors
    wire logic count_err = checking && mismatch;
    wire logic err_hit = count_err && (err_count + 8'h01 >= ERR_LIMIT_V);
    wire logic win_end = (win_count == WIN_LAST_V);
    // A window closes on its last character, on abort or out of sync
    wire logic window_restart = !checking || err_hit || win_end;

    // Next state
    // Leaving self-test always returns to pass-through
    always_comb
    begin
        next_state = state;
        case (state)
            ST_PASS:
                if (selftest_on)
                    next_state = ST_SEARCH;
            ST_SEARCH:
                if (!selftest_on)
                    next_state = ST_PASS;
                else if (start_seen)
                    next_state = ST_CHECK;                        // [R7]
            ST_CHECK:
                if (!selftest_on)
                    next_state = ST_PASS;
                else if (err_hit)
                    next_state = ST_SEARCH;                       // [R10] [R14]
            default:
                next_state = ST_PASS;
        endcase
    end

    // Generator next value
    always_comb
    begin
        next_pattern = START_STATE;
        case (next_state)
            ST_CHECK:
                if (state == ST_SEARCH)
                    next_pattern = START_STATE;
                else
                    next_pattern = pattern_step;                  // [R4]
            default:
                next_pattern = START_STATE;                       // [R5] [R10]
        endcase
    end

    // In search the start code is matched; the generator then loads data 01,
    // the slot after 00, and steps one slot per following character.
    wire logic [STATE_W-1:0] load_pattern =
        (state == ST_SEARCH && next_state == ST_CHECK)
        ? pattern_step : next_pattern;

    // Checker state
    always_ff @(posedge ref_clk or posedge sys_rst)                // [R13]
    begin
        if (sys_rst)
            state <= ST_PASS;
        else
            state <= next_state;
    end

    // Generator register
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pattern_shift_generator <= START_STATE;
        else
            pattern_shift_generator <= load_pattern;
    end

    // Error count within a window of checked characters
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            err_count <= 8'h00;
            win_count <= 16'h0000;
        end
        else if (window_restart)
        begin
            err_count <= 8'h00;                                   // [R14]
            win_count <= 16'h0000;
        end
        else
        begin
            err_count <= err_count + {7'h00, count_err};
            win_count <= win_count + 16'h0001;
        end
    end

    // Output register
    wire logic [CODE_W-1:0] next_char =
        selftest_on ? gen_code : decoded_code;                    // [R1] [R2]
    wire logic next_special =
        selftest_on ? gen_special : decoded_special;              // [R12]
    // Decoder errors are dropped while in self-test
    wire logic next_violation =
        selftest_on ? count_err : decoded_error;      // [R6] [R8] [R12]
    wire logic next_rvs = selftest_on && count_err;               // [R7]
    // Sync shows as soon as the start code is taken
    wire logic next_synced = (next_state == ST_CHECK);
    // No progress pulse on the aborting slot
    wire logic next_full = checking && selftest_on && !err_hit
                         && at_loop_start;                        // [R9]

    // Character and command flag toward the formatter
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            char_out <= CODE_RST;
            special_or_data_flag <= 1'b0;
        end
        else
        begin
            char_out <= next_char;
            special_or_data_flag <= next_special;
        end
    end

    // Error indications
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            code_violation_out <= 1'b0;
            receive_violation_signal <= 1'b0;
        end
        else
        begin
            code_violation_out <= next_violation;
            receive_violation_signal <= next_rvs;                 // [R7]
        end
    end

    // Loop progress and sync status
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            receive_full_flag <= 1'b0;
            selftest_synced <= 1'b0;
        end
        else
        begin
            receive_full_flag <= next_full;                       // [R9]
            selftest_synced <= next_synced;
        end
    end

endmodule : receive_bist_pattern_checker

`default_nettype wire

// *** design/rx_selftest_pkg.sv ***
// Constants and types shared by the receive self-test pattern checker.
// Operation
// R1: Outside self-test the output register just passes each decoded character on.
// R2: With receive_selftest_enable_n low the output register becomes a pattern shift generator and checker.
// R3: The generator runs a repeating 511-character sequence over data and command codes.
// R4: The remote transmitter sends the same sequence from an identical generator.
// R5: The generator starts at the loop start code, data 00, which occurs once per loop.
// R6: Once synchronised, every mismatch between received and generated characters shows on code_violation_out.
// R7: receive_violation_signal flags mismatches only after the loop start has been seen.
// R8: In self-test, decoder code and disparity errors raise no error indication.
// R9: In self-test receive_full_flag pulses for exactly one character clock per completed loop; the code gives none when it aborts on the loop start slot.
// R10: On excessive errors the checker stops comparing, reloads the start state and searches again.
// R11: The sequence starts with data 00, then command JK, ends with data 01, then wraps; the code follows data 00 with data 01 and ends the loop on command 00.
// R12: In normal decoding code_violation_out marks invalid codes, and special_or_data_flag is high for commands.
// R13: The checker runs on the recovered character clock, the bit clock divided by 10 or 12.
// R14: The abort happens when a parameterised error count is reached within a window of characters.
package rx_selftest_pkg;

    // Character: command flag above an 8-bit code
    localparam int CODE_W = 8;
    localparam int STATE_W = 9;
    localparam int LOOP_LEN = 511;

    // Generator start state is the loop start code, data 00
    localparam logic [STATE_W-1:0] START_STATE = 9'h000;
    // Feedback taps of the 9-stage generator (XNOR form)
    localparam int TAP_A = 8;
    localparam int TAP_B = 4;

    // Abort defaults
    localparam int ERR_LIMIT_DEF = 8;
    localparam int ERR_WINDOW_DEF = 64;

    // Reset values of the outputs
    localparam logic [CODE_W-1:0] CODE_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_PASS = 3'b001,
        ST_SEARCH = 3'b010,
        ST_CHECK = 3'b100
    } check_state_type;

endpackage : rx_selftest_pkg

// *** bench/remote_pattern_source.sv ***
// Far-end model sending the self-test sequence
`timescale 1ns/1ps
`default_nettype none
module remote_pattern_source
(
    // Clock and control
    input wire logic ref_clk,
    input wire logic run,
    input wire logic flip,
    // Character toward the receiver
    output logic [7:0] code,
    output logic special
);
    logic [8:0] s = 9'h000;
    // Same generator as the receiver, one character per clock
    always @(posedge ref_clk)
        s <= #1 run ? {s[7:0], ~(s[8] ^ s[4])} : 9'h000;
    assign code = s[7:0] ^ {7'h00, flip};
    assign special = s[8];
endmodule : remote_pattern_source
`default_nettype wire

// *** bench/receive_bist_pattern_checker_sva.sv ***
// Assertions on the self-test checker ports
`timescale 1ns/1ps
`default_nettype none
module rx_bist_sva
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic receive_selftest_enable_n,
    input wire logic [7:0] decoded_code,
    input wire logic decoded_special,
    input wire logic decoded_error,
    input wire logic [7:0] char_out,
    input wire logic special_or_data_flag,
    input wire logic code_violation_out,
    input wire logic receive_violation_signal,
    input wire logic receive_full_flag,
    input wire logic selftest_synced
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    int gap;
    logic seen;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gap <= 0;
            seen <= 1'b0;
        end
        else
        begin
            gap <= receive_full_flag ? 1 : gap + 1;
            if (!selftest_synced) seen <= 1'b0;
            else if (receive_full_flag) seen <= 1'b1;
        end
    end
    a_pass_code: assert property (receive_selftest_enable_n |=>
        char_out == $past(decoded_code)
        && special_or_data_flag == $past(decoded_special))
        else $error("pass-through character wrong");
    a_pass_error: assert property (receive_selftest_enable_n |=>
        code_violation_out == $past(decoded_error))
        else $error("pass-through violation wrong");
    a_test_violation: assert property (!$past(receive_selftest_enable_n)
        |-> code_violation_out == receive_violation_signal)
        else $error("violation not from compare");
    a_viol_synced: assert property (receive_violation_signal
        |-> $past(selftest_synced)) else $error("violation before sync");
    a_sync_start: assert property ($rose(selftest_synced)
        |-> $past(decoded_code) == 8'h00 && !$past(decoded_special))
        else $error("sync without start code");
    a_full_cause: assert property (receive_full_flag |->
        $past(selftest_synced) && !$past(receive_selftest_enable_n))
        else $error("full pulse outside test");
    a_full_gap: assert property (receive_full_flag && seen |-> gap == 511)
        else $error("loop length wrong");
    a_gen_step: assert property (selftest_synced && $past(selftest_synced)
        |-> {special_or_data_flag, char_out} == {$past(char_out),
        ~($past(special_or_data_flag) ^ $past(char_out[4]))})
        else $error("generator step wrong");
    a_abort_flag: assert property ($fell(selftest_synced)
        && !$past(receive_selftest_enable_n) |-> receive_violation_signal)
        else $error("abort without mismatch");
endmodule : rx_bist_sva
bind receive_bist_pattern_checker rx_bist_sva rx_bist_sva_i (.*);
`default_nettype wire

// *** bench/receive_bist_pattern_checker_bench.sv ***
// Self-checking bench for the self-test pattern checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("unexpected %0t: got %h exp %h", $time, a, b); end end
module receive_bist_pattern_checker_bench;
    logic ref_clk = 0, sys_rst = 1, en_n = 1, use_src = 0, run = 0, flip = 0;
    logic [7:0] rnd_code = 0, src_code, char_out;
    logic rnd_spec = 0, rnd_err = 0, src_spec, spec, vlt, rvs, full, synced;
    int failures = 0, num_checks = 0, nfull = 0, nviol = 0, i;
    integer seed = 32'h0d58b6fb;
    receive_bist_pattern_checker #(.ERR_LIMIT(4), .ERR_WINDOW(16))
        receive_bist_pattern_checker_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .receive_selftest_enable_n(en_n),
        .decoded_code(use_src ? src_code : rnd_code),
        .decoded_special(use_src ? src_spec : rnd_spec),
        .decoded_error(rnd_err), .char_out(char_out),
        .special_or_data_flag(spec), .code_violation_out(vlt),
        .receive_violation_signal(rvs), .receive_full_flag(full),
        .selftest_synced(synced));
    remote_pattern_source remote_pattern_source_i (.ref_clk(ref_clk),
        .run(run), .flip(flip), .code(src_code), .special(src_spec));
    initial forever #10 ref_clk = ~ref_clk;
    always @(negedge ref_clk)
    begin
        nfull += full;
        nviol += rvs;
    end
    function automatic logic [9:0] pass_exp(logic [7:0] c, logic s, logic e);
        return {e, s, c};
    endfunction : pass_exp
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic randin();
        rnd_code = 8'($random(seed)) | 8'h01; // Never the start code
        rnd_spec = 1'($random(seed));
        rnd_err = 1'($random(seed));
    endtask : randin
    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    initial
    begin
        #100000;
        failures++;
        final_report();
    end
    initial
    begin
        tick(20);
        sys_rst = 0;
        for (i = 0; i < 40; i++)
        begin
            randin();
            tick(1);
            `CHK({vlt, spec, char_out}, pass_exp(rnd_code, rnd_spec, rnd_err))
        end
        en_n = 0;
        for (i = 0; i < 60; i++)
        begin
            randin();
            tick(1);
            `CHK(vlt, 1'b0)
        end
        `CHK(synced | (nviol != 0) | (nfull != 0), 1'b0)
        use_src = 1;
        run = 1;
        tick(2);
        `CHK(synced, 1'b1)
        for (i = 0; i < 1100; i++)
        begin
            rnd_err = 1'($random(seed));
            tick(1);
            `CHK(vlt, 1'b0)
        end
        `CHK(nfull, 2)
        `CHK(nviol, 0)
        for (i = 0; i < 3; i++)
        begin
            flip = 1;
            tick(1);
            `CHK({vlt, rvs}, 2'b11)
            flip = 0;
            tick(20);
        end
        `CHK(nviol, 3)
        flip = 1;
        for (i = 0; i < 32 && synced; i++) tick(1);
        `CHK(synced, 1'b0)
        flip = 0;
        for (i = 0; i < 520 && !synced; i++) tick(1);
        `CHK(synced, 1'b1)
        final_report();
    end
endmodule : receive_bist_pattern_checker_bench
`default_nettype wire
